//--- chain_pkg.sv
package chain_pkg;
   // ---------------------------------------------------------------
   // Frame header fields
   // ---------------------------------------------------------------
   localparam int HDR_CMD_BIT = 7;
   localparam int HDR_TYPE_MSB = 6;
   localparam int HDR_TYPE_LSB = 4;
   localparam int HDR_SIZE_MSB = 2;
   localparam logic [2:0] TYPE_SINGLE_READ = 3'h0;
   localparam logic [2:0] TYPE_SINGLE_WRITE = 3'h1;
   localparam logic [2:0] TYPE_STACK_READ = 3'h2;
   localparam logic [2:0] TYPE_STACK_WRITE = 3'h3;
   localparam logic [2:0] TYPE_BCAST_READ = 3'h4;
   localparam logic [2:0] TYPE_BCAST_WRITE = 3'h5;
   localparam logic [2:0] TYPE_REVERSE_WRITE = 3'h6;
   localparam logic [2:0] READ_SIZE = 3'h0;
   // ---------------------------------------------------------------
   // Frame lengths and CRC
   // ---------------------------------------------------------------
   localparam logic [7:0] PROTO_LAST = 8'h06;
   localparam logic [3:0] MAX_WRITE_BYTES = 4'h8;
   localparam logic [15:0] CRC_INIT = 16'hffff;
   localparam logic [15:0] CRC_POLY_REFL = 16'ha001;
   // ---------------------------------------------------------------
   // Protected key register groups
   // ---------------------------------------------------------------
   localparam logic [15:0] KEY_ONE_BASE = 16'h0100;
   localparam logic [15:0] KEY_TWO_BASE = 16'h0110;
   localparam logic [15:0] KEY_LAST_OFS = 16'h0003;

   function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] b);
      logic [15:0] c;
      c = crc ^ {8'h00, b};
      for (int i = 0; i < 8; i++)
      begin
         c = c[0] ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
      end
      return c;
   endfunction : crc_step

   function automatic logic has_node(input logic [2:0] t);
      return (t == TYPE_SINGLE_READ) || (t == TYPE_SINGLE_WRITE);
   endfunction : has_node

   function automatic logic is_read(input logic [2:0] t);
      return (t == TYPE_SINGLE_READ) || (t == TYPE_STACK_READ) || (t == TYPE_BCAST_READ);
   endfunction : is_read

   function automatic logic key_inside(input logic [15:0] a, input logic [15:0] base);
      return (a >= base) && (a <= base + KEY_LAST_OFS);
   endfunction : key_inside

   function automatic logic key_cover(input logic [15:0] first, input logic [15:0] last,
                                      input logic [15:0] base);
      return (first <= base) && (last >= base + KEY_LAST_OFS);
   endfunction : key_cover
endpackage : chain_pkg

//--- chain_link_if.sv
`timescale 1ns/1ps
interface chain_link_if;
   logic cmd_valid;
   logic [7:0] cmd_data;
   logic rsp_valid;
   logic [7:0] rsp_data;
   modport node (input cmd_valid, input cmd_data, output rsp_valid, output rsp_data);
   modport host (output cmd_valid, output cmd_data, input rsp_valid, input rsp_data);
endinterface : chain_link_if

//--- chain_node_end.sv
`timescale 1ns/1ps
// Contract
// - Single read: header 0x80, node, reg, count, CRC
// - Count byte holds registers minus one
// - Read headers carry size field zero
// - Read response returns count plus one bytes from start
// - Single write updates one to eight registers
// - Write size field holds bytes minus one
// - Key groups change only when written whole
// - Response: header, node, start, data, CRC high first
// - Response is six bytes longer than payload
// - Stack read answered by stack nodes only
// - Node waits for node above, then appends
// - Bad upstream CRC: no append, raise fault
// - Responses arrive highest node first
// - Stack read is ignored by non-stack nodes
// - Broadcast and reverse writes carry no node byte
// - Stack read header 0xA0, no node byte
// - Commands with bad CRC are not executed
// - At most one response per command
// - Broadcast read answered by every node
module chain_node_end (
   input wire logic ref_clk,
   input wire logic rst_n,
   chain_link_if.node link,
   input wire logic [7:0] node_id,
   input wire logic is_stack,
   input wire logic is_top,
   input wire logic up_valid,
   input wire logic [7:0] up_data,
   output logic [15:0] reg_rd_addr,
   input wire logic [7:0] reg_rdata,
   output logic reg_wr_en,
   output logic [15:0] reg_wr_addr,
   output logic [7:0] reg_wr_data,
   output logic cmd_crc_err,
   output logic up_crc_err
);
   import chain_pkg::*;

   typedef enum logic [1:0] {ST_RX, ST_APPLY, ST_WAIT_UP, ST_SEND} node_state_t;

   // ---------------------------------------------------------------
   // Upstream frame checker
   // ---------------------------------------------------------------
   logic [7:0] up_idx_ff, nxt_up_idx;
   logic [7:0] up_last_ff, nxt_up_last;
   logic [15:0] up_crc_ff, nxt_up_crc;
   logic [7:0] up_hi_ff, nxt_up_hi;
   logic up_done;
   logic up_ok;

   always_comb
   begin
      nxt_up_idx = up_idx_ff;
      nxt_up_last = up_last_ff;
      nxt_up_crc = up_crc_ff;
      nxt_up_hi = up_hi_ff;
      up_done = 1'b0;
      up_ok = ({up_hi_ff, up_data} == up_crc_ff);
      if (up_valid)
      begin
         nxt_up_idx = up_idx_ff + 8'h01;
         if (up_idx_ff == 8'h00)
         begin
            nxt_up_last = {1'b0, up_data[6:0]} + PROTO_LAST;
            nxt_up_crc = crc_step(CRC_INIT, up_data);
         end
         else if (up_idx_ff == up_last_ff)
         begin
            up_done = 1'b1;
            nxt_up_idx = 8'h00;
         end
         else if (up_idx_ff == up_last_ff - 8'h01)
         begin
            nxt_up_hi = up_data;
         end
         else
         begin
            nxt_up_crc = crc_step(up_crc_ff, up_data);
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         up_idx_ff <= 8'h00;
         up_last_ff <= 8'h00;
         up_crc_ff <= CRC_INIT;
         up_hi_ff <= 8'h00;
      end
      else
      begin
         up_idx_ff <= nxt_up_idx;
         up_last_ff <= nxt_up_last;
         up_crc_ff <= nxt_up_crc;
         up_hi_ff <= nxt_up_hi;
      end
   end

   // ---------------------------------------------------------------
   // Command intake, execution and response
   // ---------------------------------------------------------------
   node_state_t state_ff, nxt_state;
   logic [7:0] idx_ff, nxt_idx;
   logic [7:0] hdr_ff, nxt_hdr;
   logic [7:0] dst_ff, nxt_dst;
   logic [15:0] reg_ff, nxt_reg;
   logic [7:0] cnt_ff, nxt_cnt;
   logic [7:0] data_ff [MAX_WRITE_BYTES], nxt_data [MAX_WRITE_BYTES];
   logic [15:0] crc_ff, nxt_crc;
   logic [7:0] crc_hi_ff, nxt_crc_hi;
   logic [15:0] rd_addr_ff, nxt_rd_addr;
   logic wr_en_ff, nxt_wr_en;
   logic [15:0] wr_addr_ff, nxt_wr_addr;
   logic [7:0] wr_data_ff, nxt_wr_data;
   logic rsp_valid_ff, nxt_rsp_valid;
   logic [7:0] rsp_data_ff, nxt_rsp_data;
   logic cmd_err_ff, nxt_cmd_err;
   logic up_err_ff, nxt_up_err;
   logic [2:0] ftype;
   logic [7:0] nofs;
   logic [7:0] rel;
   logic [3:0] nd;
   logic [7:0] rd_n;
   logic [15:0] wa;
   logic [15:0] last_a;
   logic [7:0] tb;
   logic mine_wr;
   logic mine_rd;
   logic blocked;

   always_comb
   begin
      ftype = hdr_ff[HDR_TYPE_MSB:HDR_TYPE_LSB];
      nofs = {7'h00, has_node(ftype)};
      rel = idx_ff - nofs;
      nd = is_read(ftype) ? 4'h1 : ({1'b0, hdr_ff[HDR_SIZE_MSB:0]} + 4'h1);
      rd_n = {1'b0, cnt_ff[6:0]} + 8'h01;
      wa = reg_ff + {8'h00, idx_ff};
      last_a = reg_ff + {12'h000, nd - 4'h1};
      blocked = (key_inside(wa, KEY_ONE_BASE) && !key_cover(reg_ff, last_a, KEY_ONE_BASE)) ||
                (key_inside(wa, KEY_TWO_BASE) && !key_cover(reg_ff, last_a, KEY_TWO_BASE));
      mine_wr = ((ftype == TYPE_SINGLE_WRITE) && (dst_ff == node_id)) ||
                ((ftype == TYPE_STACK_WRITE) && is_stack) ||
                (ftype == TYPE_BCAST_WRITE) || (ftype == TYPE_REVERSE_WRITE);
      mine_rd = ((ftype == TYPE_SINGLE_READ) && (dst_ff == node_id)) ||
                ((ftype == TYPE_STACK_READ) && is_stack) ||
                (ftype == TYPE_BCAST_READ);
      tb = 8'h00;
      nxt_state = state_ff;
      nxt_idx = idx_ff;
      nxt_hdr = hdr_ff;
      nxt_dst = dst_ff;
      nxt_reg = reg_ff;
      nxt_cnt = cnt_ff;
      nxt_data = data_ff;
      nxt_crc = crc_ff;
      nxt_crc_hi = crc_hi_ff;
      nxt_rd_addr = rd_addr_ff;
      nxt_wr_en = 1'b0;
      nxt_wr_addr = wr_addr_ff;
      nxt_wr_data = wr_data_ff;
      nxt_rsp_valid = up_valid;
      nxt_rsp_data = up_data;
      nxt_cmd_err = 1'b0;
      nxt_up_err = 1'b0;
      unique case (state_ff)
         ST_RX:
         begin
            if (link.cmd_valid)
            begin
               nxt_idx = idx_ff + 8'h01;
               if (idx_ff == 8'h00)
               begin
                  // Stray bytes without the command bit are dropped to regain sync
                  nxt_idx = link.cmd_data[HDR_CMD_BIT] ? 8'h01 : 8'h00;
                  nxt_hdr = link.cmd_data;
                  nxt_crc = crc_step(CRC_INIT, link.cmd_data);
               end
               else if (rel == {4'h0, nd} + 8'h04)
               begin
                  nxt_idx = 8'h00;
                  if ({crc_hi_ff, link.cmd_data} != crc_ff)
                  begin
                     nxt_cmd_err = 1'b1;
                  end
                  else if (!is_read(ftype) && mine_wr)
                  begin
                     nxt_state = ST_APPLY;
                  end
                  else if (is_read(ftype) && mine_rd)
                  begin
                     // Single reads have nobody above to wait for
                     nxt_state = (has_node(ftype) || is_top) ? ST_SEND : ST_WAIT_UP;
                     nxt_crc = CRC_INIT;
                     nxt_rd_addr = reg_ff;
                  end
               end
               else if (rel == {4'h0, nd} + 8'h03)
               begin
                  nxt_crc_hi = link.cmd_data;
               end
               else
               begin
                  nxt_crc = crc_step(crc_ff, link.cmd_data);
                  if (rel == 8'h00)
                  begin
                     nxt_dst = link.cmd_data;
                  end
                  else if (rel == 8'h01)
                  begin
                     nxt_reg[15:8] = link.cmd_data;
                  end
                  else if (rel == 8'h02)
                  begin
                     nxt_reg[7:0] = link.cmd_data;
                  end
                  else
                  begin
                     nxt_cnt = link.cmd_data;
                     nxt_data[3'(rel - 8'h03)] = link.cmd_data;
                  end
               end
            end
         end
         ST_APPLY:
         begin
            nxt_wr_en = !blocked;
            nxt_wr_addr = wa;
            nxt_wr_data = data_ff[3'(idx_ff)];
            nxt_idx = idx_ff + 8'h01;
            if (idx_ff == {4'h0, nd - 4'h1})
            begin
               nxt_idx = 8'h00;
               nxt_state = ST_RX;
            end
         end
         ST_WAIT_UP:
         begin
            if (up_done)
            begin
               nxt_state = up_ok ? ST_SEND : ST_RX;
               nxt_up_err = !up_ok;
            end
         end
         ST_SEND:
         begin
            // Upstream is silent here: the node above has already finished
            nxt_idx = idx_ff + 8'h01;
            if (idx_ff == 8'h00)
            begin
               tb = {1'b0, cnt_ff[6:0]};
            end
            else if (idx_ff == 8'h01)
            begin
               tb = node_id;
            end
            else if (idx_ff == 8'h02)
            begin
               tb = reg_ff[15:8];
            end
            else if (idx_ff == 8'h03)
            begin
               tb = reg_ff[7:0];
            end
            else if (idx_ff < rd_n + 8'h04)
            begin
               tb = reg_rdata;
               nxt_rd_addr = rd_addr_ff + 16'h0001;
            end
            else if (idx_ff == rd_n + 8'h04)
            begin
               tb = crc_ff[15:8];
            end
            else
            begin
               tb = crc_ff[7:0];
               nxt_idx = 8'h00;
               nxt_state = ST_RX;
            end
            if (idx_ff < rd_n + 8'h04)
            begin
               nxt_crc = crc_step(crc_ff, tb);
            end
            nxt_rsp_valid = 1'b1;
            nxt_rsp_data = tb;
         end
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         state_ff <= ST_RX;
         idx_ff <= 8'h00;
         hdr_ff <= 8'h00;
         dst_ff <= 8'h00;
         reg_ff <= 16'h0000;
         cnt_ff <= 8'h00;
         data_ff <= '{default: 8'h00};
         crc_ff <= CRC_INIT;
         crc_hi_ff <= 8'h00;
         rd_addr_ff <= 16'h0000;
         wr_en_ff <= 1'b0;
         wr_addr_ff <= 16'h0000;
         wr_data_ff <= 8'h00;
         rsp_valid_ff <= 1'b0;
         rsp_data_ff <= 8'h00;
         cmd_err_ff <= 1'b0;
         up_err_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         idx_ff <= nxt_idx;
         hdr_ff <= nxt_hdr;
         dst_ff <= nxt_dst;
         reg_ff <= nxt_reg;
         cnt_ff <= nxt_cnt;
         data_ff <= nxt_data;
         crc_ff <= nxt_crc;
         crc_hi_ff <= nxt_crc_hi;
         rd_addr_ff <= nxt_rd_addr;
         wr_en_ff <= nxt_wr_en;
         wr_addr_ff <= nxt_wr_addr;
         wr_data_ff <= nxt_wr_data;
         rsp_valid_ff <= nxt_rsp_valid;
         rsp_data_ff <= nxt_rsp_data;
         cmd_err_ff <= nxt_cmd_err;
         up_err_ff <= nxt_up_err;
      end
   end

   assign link.rsp_valid = rsp_valid_ff;
   assign link.rsp_data = rsp_data_ff;
   assign reg_rd_addr = rd_addr_ff;
   assign reg_wr_en = wr_en_ff;
   assign reg_wr_addr = wr_addr_ff;
   assign reg_wr_data = wr_data_ff;
   assign cmd_crc_err = cmd_err_ff;
   assign up_crc_err = up_err_ff;
endmodule : chain_node_end

//--- chain_host_end.sv
`timescale 1ns/1ps
module chain_host_end (
   input wire logic ref_clk,
   input wire logic rst_n,
   chain_link_if.host link,
   input wire logic req_valid,
   input wire logic [2:0] req_type,
   input wire logic [7:0] req_node,
   input wire logic [15:0] req_reg,
   input wire logic [7:0] req_len,
   input wire logic [63:0] req_wdata,
   output logic req_ready,
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic rx_end,
   output logic rx_crc_ok
);
   import chain_pkg::*;

   // ---------------------------------------------------------------
   // Command frame builder
   // ---------------------------------------------------------------
   logic busy_ff, nxt_busy;
   logic [7:0] idx_ff, nxt_idx;
   logic [2:0] type_ff, nxt_type;
   logic [7:0] node_ff, nxt_node;
   logic [15:0] reg_ff, nxt_reg;
   logic [7:0] len_ff, nxt_len;
   logic [63:0] wdata_ff, nxt_wdata;
   logic [15:0] crc_ff, nxt_crc;
   logic cv_ff, nxt_cv;
   logic [7:0] cd_ff, nxt_cd;
   logic rdy_ff;
   logic [7:0] rel;
   logic [3:0] nd;
   logic [7:0] tb;

   always_comb
   begin
      rel = idx_ff - {7'h00, has_node(type_ff)};
      nd = is_read(type_ff) ? 4'h1 : ({1'b0, len_ff[2:0]} + 4'h1);
      nxt_busy = busy_ff;
      nxt_idx = idx_ff;
      nxt_type = type_ff;
      nxt_node = node_ff;
      nxt_reg = reg_ff;
      nxt_len = len_ff;
      nxt_wdata = wdata_ff;
      nxt_crc = crc_ff;
      nxt_cv = 1'b0;
      nxt_cd = cd_ff;
      tb = 8'h00;
      if (!busy_ff)
      begin
         if (req_valid)
         begin
            nxt_busy = 1'b1;
            nxt_idx = 8'h00;
            nxt_type = req_type;
            nxt_node = req_node;
            nxt_reg = req_reg;
            nxt_len = req_len;
            nxt_wdata = req_wdata;
            nxt_crc = CRC_INIT;
         end
      end
      else
      begin
         nxt_idx = idx_ff + 8'h01;
         if (idx_ff == 8'h00)
         begin
            // Reads keep the size field at zero
            tb = {1'b1, type_ff, 1'b0, is_read(type_ff) ? READ_SIZE : len_ff[2:0]};
         end
         else if (rel == 8'h00)
         begin
            tb = node_ff;
         end
         else if (rel == 8'h01)
         begin
            tb = reg_ff[15:8];
         end
         else if (rel == 8'h02)
         begin
            tb = reg_ff[7:0];
         end
         else if (rel < {4'h0, nd} + 8'h03)
         begin
            tb = is_read(type_ff) ? len_ff : wdata_ff[8 * 3'(rel - 8'h03) +: 8];
         end
         else if (rel == {4'h0, nd} + 8'h03)
         begin
            tb = crc_ff[15:8];
         end
         else
         begin
            tb = crc_ff[7:0];
            nxt_busy = 1'b0;
         end
         if (idx_ff == 8'h00 || rel < {4'h0, nd} + 8'h03)
         begin
            nxt_crc = crc_step(crc_ff, tb);
         end
         nxt_cv = 1'b1;
         nxt_cd = tb;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         busy_ff <= 1'b0;
         idx_ff <= 8'h00;
         type_ff <= 3'h0;
         node_ff <= 8'h00;
         reg_ff <= 16'h0000;
         len_ff <= 8'h00;
         wdata_ff <= 64'h0000000000000000;
         crc_ff <= CRC_INIT;
         cv_ff <= 1'b0;
         cd_ff <= 8'h00;
         rdy_ff <= 1'b1;
      end
      else
      begin
         busy_ff <= nxt_busy;
         idx_ff <= nxt_idx;
         type_ff <= nxt_type;
         node_ff <= nxt_node;
         reg_ff <= nxt_reg;
         len_ff <= nxt_len;
         wdata_ff <= nxt_wdata;
         crc_ff <= nxt_crc;
         cv_ff <= nxt_cv;
         cd_ff <= nxt_cd;
         rdy_ff <= !nxt_busy;
      end
   end

   // ---------------------------------------------------------------
   // Response frame checker
   // ---------------------------------------------------------------
   logic [7:0] ri_ff, nxt_ri;
   logic [7:0] rl_ff, nxt_rl;
   logic [15:0] rc_ff, nxt_rc;
   logic [7:0] rh_ff, nxt_rh;
   logic rv_ff, nxt_rv;
   logic [7:0] rd_ff, nxt_rd;
   logic re_ff, nxt_re;
   logic ro_ff, nxt_ro;

   always_comb
   begin
      nxt_ri = ri_ff;
      nxt_rl = rl_ff;
      nxt_rc = rc_ff;
      nxt_rh = rh_ff;
      nxt_rv = link.rsp_valid;
      nxt_rd = link.rsp_data;
      nxt_re = 1'b0;
      nxt_ro = 1'b0;
      if (link.rsp_valid)
      begin
         nxt_ri = ri_ff + 8'h01;
         if (ri_ff == 8'h00)
         begin
            nxt_rl = {1'b0, link.rsp_data[6:0]} + PROTO_LAST;
            nxt_rc = crc_step(CRC_INIT, link.rsp_data);
         end
         else if (ri_ff == rl_ff)
         begin
            nxt_ri = 8'h00;
            nxt_re = 1'b1;
            nxt_ro = ({rh_ff, link.rsp_data} == rc_ff);
         end
         else if (ri_ff == rl_ff - 8'h01)
         begin
            nxt_rh = link.rsp_data;
         end
         else
         begin
            nxt_rc = crc_step(rc_ff, link.rsp_data);
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         ri_ff <= 8'h00;
         rl_ff <= 8'h00;
         rc_ff <= CRC_INIT;
         rh_ff <= 8'h00;
         rv_ff <= 1'b0;
         rd_ff <= 8'h00;
         re_ff <= 1'b0;
         ro_ff <= 1'b0;
      end
      else
      begin
         ri_ff <= nxt_ri;
         rl_ff <= nxt_rl;
         rc_ff <= nxt_rc;
         rh_ff <= nxt_rh;
         rv_ff <= nxt_rv;
         rd_ff <= nxt_rd;
         re_ff <= nxt_re;
         ro_ff <= nxt_ro;
      end
   end

   assign link.cmd_valid = cv_ff;
   assign link.cmd_data = cd_ff;
   assign req_ready = rdy_ff;
   assign rx_valid = rv_ff;
   assign rx_data = rd_ff;
   assign rx_end = re_ff;
   assign rx_crc_ok = ro_ff;
endmodule : chain_host_end

//--- chain_link_checker.sv
`timescale 1ns/1ps
// ----
// Link frame checks
// ----
module chain_link_checker (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_data,
   input wire logic rsp_valid,
   input wire logic [7:0] rsp_data
);
   logic [7:0] cnt_ff, nxt_cnt, hdr_ff, nxt_hdr, ri_ff, nxt_ri, rl_ff, nxt_rl;
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   // Response length comes from its own header byte
   always_comb
   begin
      nxt_cnt = cmd_valid ? cnt_ff + 8'h01 : 8'h00;
      nxt_hdr = (cmd_valid && cnt_ff == 8'h00) ? cmd_data : hdr_ff;
      nxt_rl = (rsp_valid && ri_ff == 8'h00) ? {1'b0, rsp_data[6:0]} + 8'h07 : rl_ff;
      nxt_ri = ri_ff;
      if (rsp_valid)
         nxt_ri = (ri_ff == 8'h00 || ri_ff + 8'h01 < rl_ff) ? ri_ff + 8'h01 : 8'h00;
   end
   always_ff @(posedge ref_clk)
   begin
      cnt_ff <= rst_n ? nxt_cnt : 8'h00;
      hdr_ff <= rst_n ? nxt_hdr : 8'h00;
      ri_ff <= rst_n ? nxt_ri : 8'h00;
      rl_ff <= rst_n ? nxt_rl : 8'h00;
   end
   sequence s_rd7;
      cmd_valid [*7] ##1 !cmd_valid;
   endsequence
   sequence s_rd6;
      cmd_valid [*6] ##1 !cmd_valid;
   endsequence
   chk_hdr_mark: assert property ($rose(cmd_valid) |-> cmd_data[7])
      else $error("header lacks command bit");
   chk_rd_size_zero: assert property ($rose(cmd_valid) &&
      cmd_data[6:4] inside {3'h0, 3'h2, 3'h4} |-> cmd_data[2:0] == 3'h0)
      else $error("read header size not zero");
   chk_single_rd_len: assert property ($rose(cmd_valid) && cmd_data == 8'h80 |-> s_rd7)
      else $error("single read frame length");
   chk_stack_rd_len: assert property ($rose(cmd_valid) && cmd_data == 8'ha0 |-> s_rd6)
      else $error("stack read frame length");
   chk_single_wr_len: assert property ($fell(cmd_valid) && hdr_ff[6:4] == 3'h1
      |-> cnt_ff == {5'h00, hdr_ff[2:0]} + 8'h07) else $error("write frame length");
   chk_bcast_wr_len: assert property ($fell(cmd_valid) &&
      hdr_ff[6:4] inside {3'h3, 3'h5, 3'h6} |-> cnt_ff == {5'h00, hdr_ff[2:0]} + 8'h06)
      else $error("address-free write frame length");
   chk_rsp_hdr_form: assert property (rsp_valid && ri_ff == 8'h00 |-> !rsp_data[7])
      else $error("response header form");
   chk_rsp_unbroken: assert property (ri_ff != 8'h00 |-> rsp_valid)
      else $error("response frame broken");
endmodule : chain_link_checker

//--- chain_transaction_frame_handler_tb.sv
`timescale 1ns/1ps
// ----
// Host and node ends face to face
// ----
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin mismatches++; \
   $display("unexpected at %0t: got %h want %h", $time, (a), (e)); end end
module chain_transaction_frame_handler_tb;
   logic ref_clk = 1'b0, rst_n = 1'b0, rv = 1'b0, pv = 1'b0, sel = 1'b0, stk = 1'b0, top = 1'b1;
   logic [2:0] rt = 3'h0;
   logic [7:0] rn = 8'h00, rl = 8'h00, pd = 8'h00, id = 8'h03;
   logic [15:0] rr = 16'h0000;
   logic rdy, xv, xe, xok, we, ce, ue, bce, bwe;
   logic [7:0] xd, wd;
   logic [15:0] ra, wa;
   int mismatches = 0, comparisons = 0, nend = 0, nok = 0, nue = 0, nce = 0, nbw = 0;
   logic [7:0] rxq[$];
   logic [23:0] wq[$];
   chain_link_if link();
   chain_link_if link_b();
   always #5 ref_clk = ~ref_clk;
   // Second link carries hand-made command frames
   assign link_b.cmd_valid = pv & sel;
   assign link_b.cmd_data = pd;
   chain_host_end i_chain_host_end (.ref_clk, .rst_n, .link(link.host), .req_valid(rv),
      .req_type(rt), .req_node(rn), .req_reg(rr), .req_len(rl),
      .req_wdata(64'h8877665544332211), .req_ready(rdy), .rx_valid(xv), .rx_data(xd),
      .rx_end(xe), .rx_crc_ok(xok));
   chain_node_end i_chain_node_end (.ref_clk, .rst_n, .link(link.node), .node_id(id),
      .is_stack(stk), .is_top(top), .up_valid(pv & ~sel), .up_data(pd), .reg_rd_addr(ra),
      .reg_rdata(ra[7:0] ^ 8'h5a), .reg_wr_en(we), .reg_wr_addr(wa), .reg_wr_data(wd),
      .cmd_crc_err(ce), .up_crc_err(ue));
   chain_node_end i_chain_node_end_b (.ref_clk, .rst_n, .link(link_b.node), .node_id(id),
      .is_stack(stk), .is_top(top), .up_valid(1'b0), .up_data(8'h00), .reg_rd_addr(),
      .reg_rdata(8'h00), .reg_wr_en(bwe), .reg_wr_addr(), .reg_wr_data(),
      .cmd_crc_err(bce), .up_crc_err());
   chain_link_checker i_chain_link_checker (.ref_clk, .rst_n, .cmd_valid(link.cmd_valid),
      .cmd_data(link.cmd_data), .rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data));
   always @(posedge ref_clk)
   begin
      if (xv === 1'b1)
         rxq.push_back(xd);
      if (xe === 1'b1)
         nend++;
      if (xe === 1'b1)
         nok += (xok === 1'b1);
      if (we === 1'b1)
         wq.push_back({wa, wd});
      nue += (ue === 1'b1);
      nce += (ce === 1'b1) + (bce === 1'b1);
      nbw += (bwe === 1'b1);
   end
   function automatic logic [15:0] crc(input logic [7:0] q[$]);
      logic [15:0] c;
      c = 16'hffff;
      foreach (q[i])
      begin
         c = c ^ {8'h00, q[i]};
         for (int k = 0; k < 8; k++)
            c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
      end
      return c;
   endfunction : crc
   // Read answer of node n from 0x0215; data is the address low byte scrambled
   function automatic void mk(input logic [7:0] n, l, output logic [7:0] f[$]);
      logic [15:0] c;
      f = {l, n, 8'h02, 8'h15};
      for (int i = 0; i <= l; i++)
         f.push_back((8'h15 + 8'(i)) ^ 8'h5a);
      c = crc(f);
      f.push_back(c[15:8]);
      f.push_back(c[7:0]);
   endfunction : mk
   task push(input logic [7:0] f[$]);
      foreach (f[i])
      begin
         @(negedge ref_clk);
         pv = 1'b1;
         pd = f[i];
      end
      @(negedge ref_clk);
      pv = 1'b0;
      pd = ~pd;
   endtask : push
   task req(input logic [2:0] t, input logic [7:0] n, l, input logic [15:0] r);
      int k;
      k = 0;
      rxq = {};
      wq = {};
      nend = 0;
      nok = 0;
      nue = 0;
      @(negedge ref_clk);
      rv = 1'b1;
      rt = t;
      rn = n;
      rl = l;
      rr = r;
      while (rdy !== 1'b1 && k++ < 99)
         @(negedge ref_clk);
      @(negedge ref_clk);
      rv = 1'b0;
      while (rdy !== 1'b1 && k++ < 199)
         @(negedge ref_clk);
   endtask : req
   // Idle tail shows any surplus frame
   task settle(input int n);
      int k;
      k = 0;
      while (nend < n && k++ < 400)
         @(negedge ref_clk);
      repeat (20) @(negedge ref_clk);
   endtask : settle
   task check_at(input int b, input logic [7:0] n, l);
      logic [7:0] f[$];
      mk(n, l, f);
      foreach (f[i])
         `CHK(rxq[b + i], f[i])
   endtask : check_at
   task t_single;
      logic [23:0] tab[3] = '{24'h030b01, 24'h030001, 24'h050b00};
      foreach (tab[i])
      begin
         req(3'h0, tab[i][23:16], tab[i][15:8], 16'h0215);
         settle(int'(tab[i][7:0]));
         `CHK(nend, int'(tab[i][7:0]))
         `CHK(rxq.size(), tab[i][7:0] * (tab[i][15:8] + 8'h07))
         `CHK(nok, nend)
         if (tab[i][0])
            check_at(0, tab[i][23:16], tab[i][15:8]);
      end
   endtask : t_single
   task t_write;
      logic [31:0] tab[7] = '{32'h12020003, 32'h17020008, 32'h11010100, 32'h13010004,
         32'h50010501, 32'h60010501, 32'h30010501};
      stk = 1'b1;
      foreach (tab[i])
      begin
         req(tab[i][30:28], id, {4'h0, tab[i][27:24]}, tab[i][23:8]);
         settle(0);
         `CHK(wq.size(), int'(tab[i][7:0]))
         `CHK(nend, 0)
         for (int k = 0; k < tab[i][7:0]; k++)
            `CHK(wq[k], {tab[i][23:8] + 16'(k), 8'h11 * 8'(k + 1)})
      end
   endtask : t_write
   task t_multi;
      logic [15:0] tab[4] = '{16'h2102, 16'h2001, 16'h4002, 16'h2111};
      logic [7:0] f[$];
      top = 1'b0;
      foreach (tab[i])
      begin
         stk = tab[i][8];
         req(tab[i][14:12], 8'h00, 8'h0b, 16'h0215);
         repeat (3) @(negedge ref_clk);
         mk(id + 8'h01, 8'h0b, f);
         f[17] = f[17] ^ {7'h00, tab[i][4]};
         push(f);
         settle(int'(tab[i][3:0]));
         `CHK(nend, int'(tab[i][3:0]))
         `CHK(nue, int'(tab[i][4]))
         `CHK(nok, int'(tab[i][3:0]) - int'(tab[i][4]))
         if (!tab[i][4])
            check_at(0, id + 8'h01, 8'h0b);
         if (tab[i][3:0] == 4'h2)
            check_at(18, id, 8'h0b);
      end
   endtask : t_multi
   task t_bad_cmd;
      logic [7:0] f[$];
      logic [15:0] c;
      sel = 1'b1;
      f = {8'h90, id, 8'h02, 8'h00, 8'h5a};
      c = crc(f);
      f.push_back(c[15:8]);
      f.push_back(~c[7:0]);
      push(f);
      repeat (10) @(negedge ref_clk);
      `CHK(nce, 1)
      `CHK(nbw, 0)
      sel = 1'b0;
   endtask : t_bad_cmd
   task tally_and_finish;
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   initial
   begin
      repeat (12) @(negedge ref_clk);
      rst_n = 1'b1;
      t_single();
      t_write();
      t_multi();
      t_bad_cmd();
      tally_and_finish();
   end
   // About fifteen times the expected run
   initial
   begin
      #100us;
      mismatches++;
      tally_and_finish();
   end
endmodule : chain_transaction_frame_handler_tb
